// ---- design/ppm_pin_cell.sv ----
// one pin: merges override sources and derives pad controls
`timescale 1ns/100ps
module ppm_pin_cell #(
    parameter int NSRC = 2
) (
    input  wire logic [NSRC-1:0] pu_oe,
    input  wire logic [NSRC-1:0] pu_ov,
    input  wire logic [NSRC-1:0] dd_oe,
    input  wire logic [NSRC-1:0] dd_ov,
    input  wire logic [NSRC-1:0] pv_oe,
    input  wire logic [NSRC-1:0] pv_ov,
    input  wire logic [NSRC-1:0] tog,
    input  wire logic [NSRC-1:0] ie_oe,
    input  wire logic [NSRC-1:0] ie_ov,
    input  wire logic            direction_bit,
    input  wire logic            port_latch_bit,
    input  wire logic            global_pullup_kill,
    input  wire logic            sleep_clamp,
    output logic                 pullup_en,
    output logic                 drive_en,
    output logic                 drive_val,
    output logic                 input_en,
    output logic                 toggle_req,
    output logic                 eff_pu_oe,
    output logic                 eff_dd_oe,
    output logic                 eff_pv_oe,
    output logic                 eff_ie_oe
);
    logic pu_v;
    logic dd_v;
    logic pv_v;
    logic ie_v;

    // lowest source index wins; loop runs downward so it assigns last
    always_comb begin
        eff_pu_oe = 1'b0;
        eff_dd_oe = 1'b0;
        eff_pv_oe = 1'b0;
        eff_ie_oe = 1'b0;
        pu_v      = 1'b0;
        dd_v      = 1'b0;
        pv_v      = 1'b0;
        ie_v      = 1'b0;
        for (int s = NSRC - 1; s >= 0; s--) begin
            if (pu_oe[s]) begin
                eff_pu_oe = 1'b1;
                pu_v      = pu_ov[s];
            end
            if (dd_oe[s]) begin
                eff_dd_oe = 1'b1;
                dd_v      = dd_ov[s];
            end
            if (pv_oe[s]) begin
                eff_pv_oe = 1'b1;
                pv_v      = pv_ov[s];
            end
            if (ie_oe[s]) begin
                eff_ie_oe = 1'b1;
                ie_v      = ie_ov[s];
            end
        end
    end

    // pad controls from merged overrides or plain port bits
    always_comb begin
        if (eff_pu_oe) begin
            pullup_en = pu_v;
        end else begin
            pullup_en = !direction_bit && port_latch_bit && !global_pullup_kill;
        end
        drive_en   = eff_dd_oe ? dd_v : direction_bit;
        drive_val  = eff_pv_oe ? pv_v : port_latch_bit;
        input_en   = eff_ie_oe ? ie_v : !sleep_clamp;
        toggle_req = |tog;
    end
endmodule : ppm_pin_cell

// ---- design/ppm_port_mux.sv ----
// port with alternate-function overrides, register port and pad controls
`timescale 1ns/100ps
`include "ppm_consts.svh"
module ppm_port_mux #(
    parameter int W    = 8,
    parameter int NEXT = 1
) (
    input  wire logic                      ref_clk,
    input  wire logic                      arst_n,
    input  wire ppm_pkg::ppm_addr_t        reg_addr,
    input  wire ppm_pkg::ppm_byte_t        reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output ppm_pkg::ppm_byte_t             reg_rdata_ff,
    input  wire ppm_pkg::ppm_sleep_e       sleep_mode,
    input  wire logic [NEXT-1:0][W-1:0]    pullup_override_enable,
    input  wire logic [NEXT-1:0][W-1:0]    pullup_override_value,
    input  wire logic [NEXT-1:0][W-1:0]    direction_override_enable,
    input  wire logic [NEXT-1:0][W-1:0]    direction_override_value,
    input  wire logic [NEXT-1:0][W-1:0]    port_value_override_enable,
    input  wire logic [NEXT-1:0][W-1:0]    port_value_override_value,
    input  wire logic [NEXT-1:0][W-1:0]    port_toggle_override,
    input  wire logic [NEXT-1:0][W-1:0]    input_enable_override_enable,
    input  wire logic [NEXT-1:0][W-1:0]    input_enable_override_value,
    input  wire logic [W-1:0]              pad_in,
    input  wire logic [W-1:0]              pad_analog_in,
    output logic [W-1:0]                   pad_out_ff,
    output logic [W-1:0]                   pad_oe_ff,
    output logic [W-1:0]                   pad_pullup_ff,
    output logic [W-1:0]                   pad_input_en_ff,
    output logic [W-1:0]                   schmitt_output_tap,
    output logic [W-1:0]                   pin_change_irq_source,
    output logic [W-1:0]                   analog_pad_link
);
    import ppm_pkg::*;

    localparam int NSRC = NEXT + 1;
    localparam ppm_byte_t RST_CTL = `PPM_RST_CONTROL;

    logic [W-1:0] direction_ff;
    logic [W-1:0] port_latch_ff;
    logic         global_pullup_kill_ff;
    logic         chg_en_ff;
    logic [W-1:0] chg_mask_ff;
    logic [W-1:0] adc_dig_dis_ff;
    logic [W-1:0] sync_stage_ff;
    logic [W-1:0] pin_input_sync_ff;

    logic [W-1:0] nxt_port_latch;
    logic [W-1:0] cell_pullup;
    logic [W-1:0] cell_drive_en;
    logic [W-1:0] cell_drive_val;
    logic [W-1:0] cell_input_en;
    logic [W-1:0] cell_toggle;
    logic [W-1:0] eff_pu_oe;
    logic [W-1:0] eff_dd_oe;
    logic [W-1:0] eff_pv_oe;
    logic [W-1:0] eff_ie_oe;
    logic [W-1:0] own_ie_oe;
    logic [W-1:0] own_ie_ov;
    logic         sleep_clamp;
    logic         port_latch_write_strobe;
    logic         pin_input_write_strobe;
    ppm_byte_t    nxt_rdata;

    // one strobe pair serves all pins of the port
    assign port_latch_write_strobe = reg_wr && (reg_addr == `PPM_OFS_PORT_LATCH);
    assign pin_input_write_strobe  = reg_wr && (reg_addr == `PPM_OFS_PIN_INPUT);

    // power-down, power-save and standby clamp the schmitt input; reset leaves state active
    always_comb begin
        case (sleep_mode)
            PPM_SLP_PWR_DOWN: sleep_clamp = 1'b1;
            PPM_SLP_PWR_SAVE: sleep_clamp = 1'b1;
            PPM_SLP_STANDBY:  sleep_clamp = 1'b1;
            default:          sleep_clamp = 1'b0;
        endcase
    end

    // port a own source: change-irq pins and converter digital disable
    assign own_ie_ov = chg_mask_ff & {W{chg_en_ff}};
    assign own_ie_oe = own_ie_ov | adc_dig_dis_ff;

    // per-pin cells; external sources rank above the port's own source
    generate
        for (genvar p = 0; p < W; p++) begin : g_pin
            logic [NSRC-1:0] s_pu_oe;
            logic [NSRC-1:0] s_pu_ov;
            logic [NSRC-1:0] s_dd_oe;
            logic [NSRC-1:0] s_dd_ov;
            logic [NSRC-1:0] s_pv_oe;
            logic [NSRC-1:0] s_pv_ov;
            logic [NSRC-1:0] s_tog;
            logic [NSRC-1:0] s_ie_oe;
            logic [NSRC-1:0] s_ie_ov;
            for (genvar s = 0; s < NEXT; s++) begin : g_src
                // each override is a separate signal for every pin
                assign s_pu_oe[s] = pullup_override_enable[s][p];
                assign s_pu_ov[s] = pullup_override_value[s][p];
                assign s_dd_oe[s] = direction_override_enable[s][p];
                assign s_dd_ov[s] = direction_override_value[s][p];
                assign s_pv_oe[s] = port_value_override_enable[s][p];
                assign s_pv_ov[s] = port_value_override_value[s][p];
                assign s_tog[s]   = port_toggle_override[s][p];
                assign s_ie_oe[s] = input_enable_override_enable[s][p];
                assign s_ie_ov[s] = input_enable_override_value[s][p];
            end
            // converter and change-irq functions never touch drive controls
            assign s_pu_oe[NEXT] = 1'b0;
            assign s_pu_ov[NEXT] = 1'b0;
            assign s_dd_oe[NEXT] = 1'b0;
            assign s_dd_ov[NEXT] = 1'b0;
            assign s_pv_oe[NEXT] = 1'b0;
            assign s_pv_ov[NEXT] = 1'b0;
            assign s_tog[NEXT]   = 1'b0;
            assign s_ie_oe[NEXT] = own_ie_oe[p];
            assign s_ie_ov[NEXT] = own_ie_ov[p];

            ppm_pin_cell #(
                .NSRC (NSRC)
            ) u_cell (
                .pu_oe              (s_pu_oe),
                .pu_ov              (s_pu_ov),
                .dd_oe              (s_dd_oe),
                .dd_ov              (s_dd_ov),
                .pv_oe              (s_pv_oe),
                .pv_ov              (s_pv_ov),
                .tog                (s_tog),
                .ie_oe              (s_ie_oe),
                .ie_ov              (s_ie_ov),
                .direction_bit      (direction_ff[p]),
                .port_latch_bit     (port_latch_ff[p]),
                .global_pullup_kill (global_pullup_kill_ff),
                .sleep_clamp        (sleep_clamp),
                .pullup_en          (cell_pullup[p]),
                .drive_en           (cell_drive_en[p]),
                .drive_val          (cell_drive_val[p]),
                .input_en           (cell_input_en[p]),
                .toggle_req         (cell_toggle[p]),
                .eff_pu_oe          (eff_pu_oe[p]),
                .eff_dd_oe          (eff_dd_oe[p]),
                .eff_pv_oe          (eff_pv_oe[p]),
                .eff_ie_oe          (eff_ie_oe[p])
            );
        end
    endgenerate

    // direction register
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            direction_ff <= `PPM_RST_DIRECTION;
        end else if (reg_wr && (reg_addr == `PPM_OFS_DIRECTION)) begin
            direction_ff <= reg_wdata[W-1:0];
        end
    end

    // latch: write, then pin-register toggles and override toggles on top
    always_comb begin
        nxt_port_latch = port_latch_ff;
        if (port_latch_write_strobe) begin
            nxt_port_latch = reg_wdata[W-1:0];
        end
        if (pin_input_write_strobe) begin
            nxt_port_latch = nxt_port_latch ^ reg_wdata[W-1:0];
        end
        nxt_port_latch = nxt_port_latch ^ cell_toggle;
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            port_latch_ff <= `PPM_RST_PORT_LATCH;
        end else begin
            port_latch_ff <= nxt_port_latch;
        end
    end

    // control, change mask and converter digital disable
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            global_pullup_kill_ff <= RST_CTL[`PPM_CTL_PULLUP_KILL];
            chg_en_ff             <= RST_CTL[`PPM_CTL_CHG_EN];
            chg_mask_ff           <= `PPM_RST_CHG_MASK;
            adc_dig_dis_ff        <= `PPM_RST_ADC_DIG_DIS;
        end else if (reg_wr) begin
            if (reg_addr == `PPM_OFS_CONTROL) begin
                global_pullup_kill_ff <= reg_wdata[`PPM_CTL_PULLUP_KILL];
                chg_en_ff             <= reg_wdata[`PPM_CTL_CHG_EN];
            end
            if (reg_addr == `PPM_OFS_CHG_MASK) begin
                chg_mask_ff <= reg_wdata[W-1:0];
            end
            if (reg_addr == `PPM_OFS_ADC_DIG_DIS) begin
                adc_dig_dis_ff <= reg_wdata[W-1:0];
            end
        end
    end

    // pad controls registered; async reset tri-states with no clock
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pad_oe_ff       <= '0;
            pad_pullup_ff   <= '0;
            pad_out_ff      <= '0;
            pad_input_en_ff <= '1;
        end else begin
            pad_oe_ff       <= cell_drive_en;
            pad_pullup_ff   <= cell_pullup;
            pad_out_ff      <= cell_drive_val;
            pad_input_en_ff <= cell_input_en;
        end
    end

    // clamped schmitt output, unsynchronized for peripherals
    assign schmitt_output_tap    = pad_in & pad_input_en_ff;
    assign pin_change_irq_source = schmitt_output_tap;
    // analog path is a plain wire to the pad, no gating
    assign analog_pad_link       = pad_analog_in;

    // two-stage synchronizer feeding the pin input register
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync_stage_ff     <= '0;
            pin_input_sync_ff <= '0;
        end else begin
            sync_stage_ff     <= schmitt_output_tap;
            pin_input_sync_ff <= sync_stage_ff;
        end
    end

    // read mux; unmapped offsets read zero
    always_comb begin
        nxt_rdata = 8'h00;
        case (reg_addr)
            `PPM_OFS_DIRECTION:   nxt_rdata[W-1:0] = direction_ff;
            `PPM_OFS_PORT_LATCH:  nxt_rdata[W-1:0] = port_latch_ff;
            `PPM_OFS_PIN_INPUT:   nxt_rdata[W-1:0] = pin_input_sync_ff;
            `PPM_OFS_CONTROL: begin
                nxt_rdata[`PPM_CTL_PULLUP_KILL] = global_pullup_kill_ff;
                nxt_rdata[`PPM_CTL_CHG_EN]      = chg_en_ff;
            end
            `PPM_OFS_CHG_MASK:    nxt_rdata[W-1:0] = chg_mask_ff;
            `PPM_OFS_ADC_DIG_DIS: nxt_rdata[W-1:0] = adc_dig_dis_ff;
            default:              nxt_rdata = 8'h00;
        endcase
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata_ff <= nxt_rdata;
        end else begin
            reg_rdata_ff <= 8'h00;
        end
    end

    // checks on pin 0, except sync, reset and read checks on the whole port; every pin runs the same cell
    a_pull_plain: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !eff_pu_oe[0] |=> pad_pullup_ff[0] ==
        (!$past(direction_ff[0]) && $past(port_latch_ff[0]) && !$past(global_pullup_kill_ff)))
        else $error("pull-up wrong without override");

    a_pull_forced: assert property (@(posedge ref_clk) disable iff (!arst_n)
        pullup_override_enable[0][0]
        |=> pad_pullup_ff[0] == $past(pullup_override_value[0][0]))
        else $error("pull-up ignores override value");

    a_dir_plain: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !eff_dd_oe[0] |=> pad_oe_ff[0] == $past(direction_ff[0]))
        else $error("driver enable not from direction bit");

    a_dir_forced: assert property (@(posedge ref_clk) disable iff (!arst_n)
        direction_override_enable[0][0]
        |=> pad_oe_ff[0] == $past(direction_override_value[0][0]))
        else $error("driver enabled against override");

    a_value_plain: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !eff_pv_oe[0] |=> pad_out_ff[0] == $past(port_latch_ff[0]))
        else $error("pin level not from latch");

    a_toggle_flip: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (cell_toggle[0] && !reg_wr) |=> port_latch_ff[0] != $past(port_latch_ff[0]))
        else $error("toggle override did not invert latch");

    a_pin_toggle: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (pin_input_write_strobe && reg_wdata[0] && !cell_toggle[0])
        |=> port_latch_ff[0] != $past(port_latch_ff[0]))
        else $error("pin register write did not toggle latch");

    a_input_clamp: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (!eff_ie_oe[0] && sleep_mode == PPM_SLP_PWR_DOWN) |=> !pad_input_en_ff[0])
        else $error("input not clamped in power-down");

    a_input_idle: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (!eff_ie_oe[0] && sleep_mode == PPM_SLP_IDLE) |=> pad_input_en_ff[0])
        else $error("input disabled in idle");

    a_sync_delay: assert property (@(posedge ref_clk) disable iff (!arst_n)
        ##2 pin_input_sync_ff == $past(schmitt_output_tap, 2))
        else $error("pin input not two cycles behind tap");

    a_reset_hiz: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $rose(arst_n) |-> (pad_oe_ff == '0) && (pad_pullup_ff == '0))
        else $error("pins not tri-stated after reset");

    a_read_once: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !reg_rd |=> reg_rdata_ff == 8'h00)
        else $error("read data outside its cycle");

    a_value_forced: assert property (@(posedge ref_clk) disable iff (!arst_n)
        port_value_override_enable[0][0]
        |=> pad_out_ff[0] == $past(port_value_override_value[0][0]))
        else $error("level ignores override");

    a_input_forced: assert property (@(posedge ref_clk) disable iff (!arst_n)
        input_enable_override_enable[0][0]
        |=> pad_input_en_ff[0] == $past(input_enable_override_value[0][0]))
        else $error("input ignores override");

    a_input_active: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (!eff_ie_oe[0] && sleep_mode == PPM_SLP_ACTIVE)
        |=> pad_input_en_ff[0])
        else $error("input off while active");

    a_clamp_deep: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (!eff_ie_oe[0] && sleep_mode inside {PPM_SLP_PWR_SAVE, PPM_SLP_STANDBY})
        |=> !pad_input_en_ff[0])
        else $error("input not clamped");

    a_chg_keep: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (!input_enable_override_enable[0][0] && chg_en_ff && chg_mask_ff[0])
        |=> pad_input_en_ff[0])
        else $error("change pin input off");

    a_conv_off: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (!input_enable_override_enable[0][0] && adc_dig_dis_ff[0] && !chg_mask_ff[0])
        |=> !pad_input_en_ff[0])
        else $error("converter pin input on");
endmodule : ppm_port_mux

// ---- shared/ppm_consts.svh ----
// constants for the port pin override mux: offsets, fields, reset values
// Behaviour
// - no pull override: pull-up when dir,latch,kill = 010
// - pull override forces pull-up to override value
// - direction bit drives output enable unless overridden
// - direction override value enables or disables driver
// - driven level from override value or latch
// - port value override sets pin output level
// - toggle override inverts the stored latch bit
// - input enable follows sleep state unless overridden
// - input enable override value decides input enable
// - schmitt tap reaches peripherals before the synchronizer
// - analog path goes straight to the pad
// - strobes per port, shared globals, per-pin overrides
// - port bit n: converter and change source n
// - all pull-ups off while reset is active
// - digital inputs enabled in reset, active, idle
// - clamp inputs in power-down, power-save, standby
// - writing one to pin input register toggles latch
// - reset tri-states every pin without a clock
`ifndef PPM_CONSTS_SVH
`define PPM_CONSTS_SVH

// register byte offsets
`define PPM_OFS_DIRECTION   8'h00
`define PPM_OFS_PORT_LATCH  8'h04
`define PPM_OFS_PIN_INPUT   8'h08
`define PPM_OFS_CONTROL     8'h0C
`define PPM_OFS_CHG_MASK    8'h10
`define PPM_OFS_ADC_DIG_DIS 8'h14

// control register fields
`define PPM_CTL_PULLUP_KILL 0
`define PPM_CTL_CHG_EN      1

// reset values
`define PPM_RST_DIRECTION   8'h00
`define PPM_RST_PORT_LATCH  8'h00
`define PPM_RST_CONTROL     8'h00
`define PPM_RST_CHG_MASK    8'h00
`define PPM_RST_ADC_DIG_DIS 8'h00

`endif

// ---- shared/ppm_pkg.sv ----
// types shared by the port pin override mux
package ppm_pkg;
    typedef logic [7:0] ppm_addr_t;
    typedef logic [7:0] ppm_byte_t;

    // operating state reported by the sleep controller
    typedef enum logic [2:0] {
        PPM_SLP_ACTIVE      = 3'h0,
        PPM_SLP_IDLE        = 3'h1,
        PPM_SLP_ADC_NR      = 3'h2,
        PPM_SLP_PWR_DOWN    = 3'h3,
        PPM_SLP_PWR_SAVE    = 3'h4,
        PPM_SLP_STANDBY     = 3'h5,
        PPM_SLP_EXT_STANDBY = 3'h6
    } ppm_sleep_e;
endpackage : ppm_pkg

// ---- verification/port_pin_override_mux_tb_top.sv ----
// self-checking bench for the port pin override mux
`timescale 1ns/100ps
`include "ppm_consts.svh"
module port_pin_override_mux_tb_top;
    import ppm_pkg::*;
    logic            ref_clk = 1'b0;
    logic            arst_n = 1'b0;
    ppm_addr_t       reg_addr = 8'h00;
    ppm_byte_t       reg_wdata = 8'h00;
    logic            reg_wr = 1'b0;
    logic            reg_rd = 1'b0;
    ppm_byte_t       reg_rdata_ff;
    ppm_sleep_e      sleep_mode = PPM_SLP_ACTIVE;
    logic [0:0][7:0] pu_oe, pu_ov, dd_oe, dd_ov, pv_oe, pv_ov, tog, ie_oe, ie_ov;
    logic [7:0]      pad_in = 8'h00;
    logic [7:0]      pad_an = 8'h00;
    logic [7:0]      p_out, p_oe, p_pu, p_ie, tap, irq, ana, syn;
    logic [7:0]      own_pins = 8'h00;
    logic [3:0]      own_kind = 4'h0;
    logic [7:0]      own_val = 8'h00;
    logic            tog_go = 1'b0;
    logic            pad_chk = 1'b0;
    logic            rd_d = 1'b0;
    int              errors = 0;
    int              num_checks = 0;
    int              cyc = 0;
    logic [7:0]      dir_s = 8'h00, lat_s = 8'h00, ctl_s = 8'h00, msk_s = 8'h00, dis_s = 8'h00;
    logic [63:0]     ev;
    ppm_byte_t       rq[$];
    logic [63:0]     pq[$];

    always #2.5 ref_clk = ~ref_clk;

    ppm_port_mux #(.W(8), .NEXT(1)) uut (.ref_clk(ref_clk), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_ff(reg_rdata_ff), .sleep_mode(sleep_mode),
        .pullup_override_enable(pu_oe), .pullup_override_value(pu_ov),
        .direction_override_enable(dd_oe), .direction_override_value(dd_ov),
        .port_value_override_enable(pv_oe), .port_value_override_value(pv_ov),
        .port_toggle_override(tog), .input_enable_override_enable(ie_oe),
        .input_enable_override_value(ie_ov), .pad_in(pad_in), .pad_analog_in(pad_an),
        .pad_out_ff(p_out), .pad_oe_ff(p_oe), .pad_pullup_ff(p_pu), .pad_input_en_ff(p_ie),
        .schmitt_output_tap(tap), .pin_change_irq_source(irq), .analog_pad_link(ana));

    ppm_periph_model u_periph (.ref_clk(ref_clk), .arst_n(arst_n), .own_pins(own_pins),
        .own_kind(own_kind), .own_val(own_val), .tog_go(tog_go), .tap_in(tap),
        .pu_oe(pu_oe), .pu_ov(pu_ov), .dd_oe(dd_oe), .dd_ov(dd_ov), .pv_oe(pv_oe),
        .pv_ov(pv_ov), .tog(tog), .ie_oe(ie_oe), .ie_ov(ie_ov), .tap_sync_ff(syn));

    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test

    task automatic cmp_rd(input ppm_byte_t got, input ppm_byte_t exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_rd

    task automatic cmp_pad(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_pad

    // expected pad picture from the bench copy of registers and overrides
    function automatic logic [63:0] expv();
        logic [7:0] pe, de, ve, ee, oo, cl, ie, tp;
        pe = own_pins & {8{own_kind[0]}};
        de = own_pins & {8{own_kind[1]}};
        ve = own_pins & {8{own_kind[2]}};
        ee = own_pins & {8{own_kind[3]}};
        oo = (msk_s & {8{ctl_s[1]}}) | dis_s;
        cl = (sleep_mode inside {PPM_SLP_PWR_DOWN, PPM_SLP_PWR_SAVE, PPM_SLP_STANDBY})
            ? 8'h00 : 8'hff;
        ie = (ee & own_val) | (~ee & oo & msk_s & {8{ctl_s[1]}}) | (~ee & ~oo & cl);
        tp = pad_in & ie;
        return {(de & own_val) | (~de & dir_s), (ve & own_val) | (~ve & lat_s),
            (pe & own_val) | (~pe & ~dir_s & lat_s & {8{~ctl_s[0]}}), ie, tp, tp, pad_an, tp};
    endfunction : expv

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : tick

    task automatic wr(input ppm_addr_t a, input ppm_byte_t d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask : wr

    task automatic rd(input ppm_addr_t a, input ppm_byte_t exp);
        rq.push_back(exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
    endtask : rd

    task automatic pchk();
        pq.push_back(expv());
        pad_chk <= 1'b1;
        @(posedge ref_clk);
        pad_chk <= 0;
        @(posedge ref_clk);
    endtask : pchk

    task automatic cfg();
        wr(`PPM_OFS_DIRECTION, dir_s);
        wr(`PPM_OFS_PORT_LATCH, lat_s);
        wr(`PPM_OFS_CONTROL, ctl_s);
        wr(`PPM_OFS_CHG_MASK, msk_s);
        wr(`PPM_OFS_ADC_DIG_DIS, dis_s);
    endtask : cfg

    // watcher: read data stands one cycle after the strobe, pads on request
    always @(posedge ref_clk) begin
        if (rd_d) begin
            cmp_rd(reg_rdata_ff, rq.pop_front());
        end
        if (pad_chk) begin
            cmp_pad({p_oe, p_out, p_pu, p_ie, tap, irq, ana, syn}, pq.pop_front());
        end
        rd_d <= reg_rd;
        cyc++;
        if (cyc >= 4000) begin
            errors++;
            finish_test();
        end
    end

    // main sequence
    initial begin
        void'($urandom(71));
        tick(20);
        pchk();
        arst_n <= 1'b1;
        tick(2);
        rd(`PPM_OFS_DIRECTION, `PPM_RST_DIRECTION);
        rd(`PPM_OFS_PORT_LATCH, `PPM_RST_PORT_LATCH);
        rd(`PPM_OFS_CONTROL, `PPM_RST_CONTROL);
        rd(`PPM_OFS_CHG_MASK, `PPM_RST_CHG_MASK);
        rd(`PPM_OFS_ADC_DIG_DIS, `PPM_RST_ADC_DIG_DIS);
        wr(8'h18, 8'ha5);
        rd(8'h18, 8'h00);
        $display("test regs done");
        repeat (12) begin
            dir_s = 8'($urandom);
            lat_s = 8'($urandom);
            ctl_s = 8'($urandom) & 8'h03;
            cfg();
            tick(2);
            pchk();
            rd(`PPM_OFS_DIRECTION, dir_s);
        end
        $display("test plain done");
        for (int k = 0; k < 5; k++) begin
            repeat (4) begin
                own_pins <= 8'($urandom);
                own_val <= 8'($urandom);
                own_kind <= (k < 4) ? 4'(1 << k) : 4'hf;
                tick(2);
                pchk();
            end
        end
        own_kind <= 4'h0;
        tick(2);
        pchk();
        $display("test override done");
        wr(`PPM_OFS_PIN_INPUT, 8'h5a);
        lat_s = lat_s ^ 8'h5a;
        rd(`PPM_OFS_PORT_LATCH, lat_s);
        tog_go <= 1'b1;
        @(posedge ref_clk);
        tog_go <= 1'b0;
        lat_s = lat_s ^ own_pins;
        tick(2);
        rd(`PPM_OFS_PORT_LATCH, lat_s);
        $display("test toggle done");
        for (int s = 0; s < 7; s++) begin
            pad_in <= 8'($urandom);
            pad_an <= 8'($urandom);
            sleep_mode <= ppm_sleep_e'(s);
            own_kind <= {s[0], 3'b000};
            msk_s = 8'($urandom);
            dis_s = 8'($urandom);
            ctl_s = 8'($urandom) & 8'h03;
            cfg();
            tick(4);
            ev = expv();
            pchk();
            rd(`PPM_OFS_PIN_INPUT, ev[31:24]);
        end
        $display("test sleep done");
        dir_s = 8'h00;
        lat_s = 8'hff;
        ctl_s = 8'h00;
        cfg();
        tick(2);
        pchk();
        arst_n <= 1'b0;
        #1;
        cmp_rd(p_pu, 8'h00);
        cmp_rd(p_oe, 8'h00);
        $display("test reset done");
        finish_test();
    end
endmodule : port_pin_override_mux_tb_top

// ---- verification/ppm_periph_model.sv ----
// peripheral model: owns alternate functions and drives the override lines
`timescale 1ns/100ps
module ppm_periph_model (
    input  wire logic       ref_clk,
    input  wire logic       arst_n,
    input  wire logic [7:0] own_pins,
    input  wire logic [3:0] own_kind,
    input  wire logic [7:0] own_val,
    input  wire logic       tog_go,
    input  wire logic [7:0] tap_in,
    output logic [0:0][7:0] pu_oe,
    output logic [0:0][7:0] pu_ov,
    output logic [0:0][7:0] dd_oe,
    output logic [0:0][7:0] dd_ov,
    output logic [0:0][7:0] pv_oe,
    output logic [0:0][7:0] pv_ov,
    output logic [0:0][7:0] tog,
    output logic [0:0][7:0] ie_oe,
    output logic [0:0][7:0] ie_ov,
    output logic [7:0]      tap_sync_ff
);
    logic [7:0] tap_meta_ff;

    // enables only on owned pins, low elsewhere so port registers rule
    assign pu_oe = own_pins & {8{own_kind[0]}};
    assign dd_oe = own_pins & {8{own_kind[1]}};
    assign pv_oe = own_pins & {8{own_kind[2]}};
    assign ie_oe = own_pins & {8{own_kind[3]}};
    assign pu_ov = own_val;
    assign dd_ov = own_val;
    assign pv_ov = own_val;
    assign ie_ov = own_val;
    assign tog   = own_pins & {8{tog_go}};

    // tap arrives raw, so resync before use
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tap_meta_ff <= 8'h00;
            tap_sync_ff <= 8'h00;
        end else begin
            tap_meta_ff <= tap_in;
            tap_sync_ff <= tap_meta_ff;
        end
    end
endmodule : ppm_periph_model
